// ==== rtl/pcg_top.v ====
// peripheral clock gating: run enables, stop keep masks, write guard, axi4-lite slave
`timescale 1ns/1ps
`include "pcg_map.vh"
module pcg_top #(
  parameter N_LO = 16,
  parameter N_HI = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire stop_req,
  input wire [N_LO-1:0] irq_lo,
  input wire [N_HI-1:0] irq_hi,
  input wire [N_LO-1:0] acc_req_lo,
  input wire [N_HI-1:0] acc_req_hi,
  output reg stop_active_r,
  output reg wake_req_r,
  output reg [N_LO-1:0] clk_en_lo_r,
  output reg [N_HI-1:0] clk_en_hi_r,
  output reg [N_LO-1:0] acc_ok_lo_r,
  output reg [N_HI-1:0] acc_ok_hi_r,
  output wire [N_LO-1:0] pclk_lo,
  output wire [N_HI-1:0] pclk_hi
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RESP = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [15:0] gate_lo_r;
  reg [15:0] gate_hi_r;
  reg [15:0] keep_lo_r;
  reg [15:0] keep_hi_r;
  reg [1:0] guard_r;
  reg [15:0] gate_lo_nxt;
  reg [15:0] gate_hi_nxt;
  reg [15:0] keep_lo_nxt;
  reg [15:0] keep_hi_nxt;
  reg [1:0] guard_nxt;
  reg [2:0] wst_r;
  reg [7:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg have_aw_r;
  reg have_w_r;
  reg stop_m1_r;
  reg stop_m2_r;
  reg [N_LO-1:0] irq_lo_m1_r;
  reg [N_LO-1:0] irq_lo_m2_r;
  reg [N_HI-1:0] irq_hi_m1_r;
  reg [N_HI-1:0] irq_hi_m2_r;
  reg [N_LO-1:0] acc_lo_m1_r;
  reg [N_LO-1:0] acc_lo_m2_r;
  reg [N_HI-1:0] acc_hi_m1_r;
  reg [N_HI-1:0] acc_hi_m2_r;

  // merge a 16-bit field under byte strobes, dropping reserved bits
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [15:0] mask;
    reg [15:0] t;
    begin
      t = old;
      if (strb[0]) begin
        t[7:0] = data[7:0];
      end
      if (strb[1]) begin
        t[15:8] = data[15:8];
      end
      merge16 = t & mask;
    end
  endfunction

  // effective clock enable: run enable, and in stop also the keep bit
  function [15:0] eff_en;
    input [15:0] run_en;
    input [15:0] keep;
    input in_stop;
    begin
      eff_en = in_stop ? (run_en & keep) : run_en;
    end
  endfunction

  function is_idx;
    input [7:0] addr;
    input [7:0] idx;
    begin
      is_idx = (addr[7:2] == idx[5:0]) && (addr[1:0] == 2'h0);
    end
  endfunction

  // write channel: collect address and data in either order
  wire do_write = have_aw_r && have_w_r && (wst_r == ST_IDLE);
  // guard codes 01 and 11 block writes to gate and keep registers
  wire guarded = guard_r[0];
  wire guard_locked = guard_r[1];
  wire w_lo = is_idx(waddr_r, `PCG_IDX_GATE_LO);
  wire w_hi = is_idx(waddr_r, `PCG_IDX_GATE_HI);
  wire w_klo = is_idx(waddr_r, `PCG_IDX_KEEP_LO);
  wire w_khi = is_idx(waddr_r, `PCG_IDX_KEEP_HI);
  wire w_grd = is_idx(waddr_r, `PCG_IDX_GUARD);
  wire w_map = w_lo | w_hi | w_klo | w_khi | w_grd;

  always @* begin
    gate_lo_nxt = gate_lo_r;
    gate_hi_nxt = gate_hi_r;
    keep_lo_nxt = keep_lo_r;
    keep_hi_nxt = keep_hi_r;
    guard_nxt = guard_r;
    if (do_write) begin
      if (!guarded) begin
        if (w_lo) begin
          gate_lo_nxt = merge16(gate_lo_r, wdata_r, wstrb_r, `PCG_MASK_LO);
        end
        if (w_hi) begin
          gate_hi_nxt = merge16(gate_hi_r, wdata_r, wstrb_r, `PCG_MASK_HI);
        end
        if (w_klo) begin
          keep_lo_nxt = merge16(keep_lo_r, wdata_r, wstrb_r, `PCG_MASK_LO);
        end
        if (w_khi) begin
          keep_hi_nxt = merge16(keep_hi_r, wdata_r, wstrb_r, `PCG_MASK_HI);
        end
      end
      if (w_grd && !guard_locked && wstrb_r[0]) begin
        guard_nxt = wdata_r[`PCG_GUARD_LSB+1:`PCG_GUARD_LSB];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      gate_lo_r <= `PCG_RST_GATE_LO;
      gate_hi_r <= `PCG_RST_GATE_HI;
      keep_lo_r <= `PCG_RST_KEEP_LO;
      keep_hi_r <= `PCG_RST_KEEP_HI;
      guard_r <= `PCG_RST_GUARD;
    end else begin
      gate_lo_r <= gate_lo_nxt;
      gate_hi_r <= gate_hi_nxt;
      keep_lo_r <= keep_lo_nxt;
      keep_hi_r <= keep_hi_nxt;
      guard_r <= guard_nxt;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= ST_IDLE;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCG_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      case (wst_r)
        ST_IDLE: begin
          if (s_axi_awvalid && !have_aw_r && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            waddr_r <= s_axi_awaddr;
            have_aw_r <= 1'b1;
          end
          if (s_axi_wvalid && !have_w_r && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            have_w_r <= 1'b1;
          end
          if (do_write) begin
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_map ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
            wst_r <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_r <= ST_IDLE;
          end
        end
        default: begin
          wst_r <= ST_IDLE;
        end
      endcase
    end
  end

  // read channel: one read at a time, answer the cycle after the address handshake
  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (is_idx(s_axi_araddr, `PCG_IDX_GATE_LO)) begin
      rd_val[15:0] = gate_lo_r;
    end else if (is_idx(s_axi_araddr, `PCG_IDX_GATE_HI)) begin
      rd_val[15:0] = gate_hi_r;
    end else if (is_idx(s_axi_araddr, `PCG_IDX_KEEP_LO)) begin
      rd_val[15:0] = keep_lo_r;
    end else if (is_idx(s_axi_araddr, `PCG_IDX_KEEP_HI)) begin
      rd_val[15:0] = keep_hi_r;
    end else if (is_idx(s_axi_araddr, `PCG_IDX_GUARD)) begin
      rd_val[`PCG_GUARD_LSB+1:`PCG_GUARD_LSB] = guard_r;
    end else if (is_idx(s_axi_araddr, `PCG_IDX_STATUS)) begin
      rd_val[0] = stop_active_r;
      rd_val[1] = wake_req_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCG_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arready) begin
        // read data must follow the address handshake, never come with it
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
      end
    end
  end

  // two-stage synchronisers for the far-side level inputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      stop_m1_r <= 1'b0;
      stop_m2_r <= 1'b0;
      irq_lo_m1_r <= {N_LO{1'b0}};
      irq_lo_m2_r <= {N_LO{1'b0}};
      irq_hi_m1_r <= {N_HI{1'b0}};
      irq_hi_m2_r <= {N_HI{1'b0}};
      acc_lo_m1_r <= {N_LO{1'b0}};
      acc_lo_m2_r <= {N_LO{1'b0}};
      acc_hi_m1_r <= {N_HI{1'b0}};
      acc_hi_m2_r <= {N_HI{1'b0}};
    end else begin
      stop_m1_r <= stop_req;
      stop_m2_r <= stop_m1_r;
      irq_lo_m1_r <= irq_lo;
      irq_lo_m2_r <= irq_lo_m1_r;
      irq_hi_m1_r <= irq_hi;
      irq_hi_m2_r <= irq_hi_m1_r;
      acc_lo_m1_r <= acc_req_lo;
      acc_lo_m2_r <= acc_lo_m1_r;
      acc_hi_m1_r <= acc_req_hi;
      acc_hi_m2_r <= acc_hi_m1_r;
    end
  end

  // stop masks each enable with its keep bit
  wire [15:0] en_lo_nxt = eff_en(gate_lo_r, keep_lo_r, stop_active_r);
  wire [15:0] en_hi_nxt = eff_en(gate_hi_r, keep_hi_r, stop_active_r);
  wire wake_nxt = stop_active_r &&
    (|(irq_lo_m2_r[15:0] & clk_en_lo_r[15:0]) || |(irq_hi_m2_r[15:0] & clk_en_hi_r[15:0]));

  always @(posedge aclk) begin
    if (!aresetn) begin
      stop_active_r <= 1'b0;
      wake_req_r <= 1'b0;
      clk_en_lo_r <= {N_LO{1'b0}};
      clk_en_hi_r <= {N_HI{1'b0}};
      acc_ok_lo_r <= {N_LO{1'b0}};
      acc_ok_hi_r <= {N_HI{1'b0}};
    end else begin
      // the wake request pulls the block out of stop even while stop_req still stands
      if (wake_nxt) begin
        stop_active_r <= 1'b0;
      end else if (stop_m2_r && !wake_req_r) begin
        stop_active_r <= 1'b1;
      end else if (!stop_m2_r) begin
        stop_active_r <= 1'b0;
      end
      wake_req_r <= wake_nxt | (wake_req_r & stop_m2_r);
      clk_en_lo_r <= en_lo_nxt;
      clk_en_hi_r <= en_hi_nxt;
      acc_ok_lo_r <= acc_lo_m2_r & en_lo_nxt;
      acc_ok_hi_r <= acc_hi_m2_r & en_hi_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_LO; gi = gi + 1) begin : g_lo
      pcg_clk_gate u_gate (
        .clk_in(aclk),
        .enable(clk_en_lo_r[gi]),
        .clk_out(pclk_lo[gi])
      );
    end
    for (gi = 0; gi < N_HI; gi = gi + 1) begin : g_hi
      pcg_clk_gate u_gate (
        .clk_in(aclk),
        .enable(clk_en_hi_r[gi]),
        .clk_out(pclk_hi[gi])
      );
    end
  endgenerate
endmodule // pcg_top

// ==== rtl/pcg_map.vh ====
// register map, field positions, reset values and protection codes of the clock gating block
`ifndef PCG_MAP_VH
`define PCG_MAP_VH

// register indices; byte address is four times the index
`define PCG_IDX_GATE_LO 8'h0C
`define PCG_IDX_GATE_HI 8'h0D
`define PCG_IDX_KEEP_LO 8'h0E
`define PCG_IDX_KEEP_HI 8'h0F
`define PCG_IDX_GUARD 8'h12
`define PCG_IDX_STATUS 8'h13

// writable masks (reserved bits forced to zero)
`define PCG_MASK_LO 16'hF455
`define PCG_MASK_HI 16'h100F

`define PCG_RST_GATE_LO 16'h0000
`define PCG_RST_GATE_HI 16'h0000
`define PCG_RST_KEEP_LO 16'h0000
`define PCG_RST_KEEP_HI 16'h0000
`define PCG_RST_GUARD 2'h0

// bits of the low group
`define PCG_B_CMPB 15
`define PCG_B_CMPA 14
`define PCG_B_DAC1 13
`define PCG_B_DAC0 12
`define PCG_B_ADC 10
`define PCG_B_I2C 6
`define PCG_B_ASER 4
`define PCG_B_SSER 2
`define PCG_B_PWM 0
// bits of the high group
`define PCG_B_PIT 12
`define PCG_B_TA3 3
`define PCG_B_TA0 0

// write guard field position and codes
`define PCG_GUARD_LSB 2
`define PCG_GUARD_OFF 2'h0
`define PCG_GUARD_ON 2'h1
`define PCG_GUARD_OFF_LOCK 2'h2
`define PCG_GUARD_ON_LOCK 2'h3

`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2

`endif

// ==== rtl/pcg_clk_gate.v ====
// glitch-free clock gate for one peripheral clock, enable held in a falling-edge flop
`timescale 1ns/1ps
module pcg_clk_gate (
  input wire clk_in,
  input wire enable,
  output wire clk_out
);
  reg en_low_r;

  // enable retimed on the falling edge: it only moves while the source clock is low,
  // so a change of enable can never cut a high phase short
  always @(negedge clk_in) begin
    en_low_r <= enable;
  end

  assign clk_out = clk_in & en_low_r;
endmodule // pcg_clk_gate

// ==== sim/pcg_top_asserts.sv ====
// port-level assertions for the peripheral clock gating block
`timescale 1ns/1ps
`include "pcg_map.vh"
module pcg_top_asserts #(
  parameter N_LO = 16,
  parameter N_HI = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire stop_active_r,
  input wire wake_req_r,
  input wire [N_LO-1:0] clk_en_lo_r,
  input wire [N_HI-1:0] clk_en_hi_r,
  input wire [N_LO-1:0] acc_ok_lo_r,
  input wire [N_LO-1:0] pclk_lo,
  input wire [N_HI-1:0] pclk_hi
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_hi_mask;
    (clk_en_hi_r & ~`PCG_MASK_HI) == 0;
  endproperty
  a_hi_mask: assert property (p_hi_mask) else $error("hi enable on a reserved bit");
  property p_lo_mask;
    (clk_en_lo_r & ~`PCG_MASK_LO) == 0;
  endproperty
  a_lo_mask: assert property (p_lo_mask) else $error("lo enable on a reserved bit");
  // gated clocks must be low just before every rising edge, no runt highs
  property p_gate_low;
    pclk_lo == 0 && pclk_hi == 0;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated clock high while aclk low");
  property p_follow;
    @(negedge aclk) $stable(clk_en_lo_r) && $stable(clk_en_hi_r)
      |-> pclk_lo == clk_en_lo_r && pclk_hi == clk_en_hi_r;
  endproperty
  a_follow: assert property (p_follow) else $error("gated clock ignores its enable");
  property p_stop_in;
    $rose(stop_active_r) |=> (clk_en_lo_r & ~$past(clk_en_lo_r)) == 0
      && (clk_en_hi_r & ~$past(clk_en_hi_r)) == 0;
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("stop entry turned a clock on");
  property p_wake_exit;
    $rose(wake_req_r) |-> !stop_active_r;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake left stop active");
  property p_wake_src;
    $rose(wake_req_r) |-> $past(stop_active_r);
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake outside stop");
  property p_acc;
    (acc_ok_lo_r & ~clk_en_lo_r & ~$past(clk_en_lo_r)) == 0;
  endproperty
  a_acc: assert property (p_acc) else $error("access passed to a stopped peripheral");
endmodule // pcg_top_asserts
bind pcg_top pcg_top_asserts #(.N_LO(N_LO), .N_HI(N_HI)) chk_u (.aclk(aclk),
  .aresetn(aresetn), .stop_active_r(stop_active_r), .wake_req_r(wake_req_r),
  .clk_en_lo_r(clk_en_lo_r), .clk_en_hi_r(clk_en_hi_r), .acc_ok_lo_r(acc_ok_lo_r),
  .pclk_lo(pclk_lo), .pclk_hi(pclk_hi));

// ==== sim/pcg_far_side.sv ====
// far side model: stop/run controller and the gated peripherals
`timescale 1ns/1ps
module pcg_far_side (
  input wire aclk,
  input wire aresetn,
  input wire go_stop,
  input wire wake_req_r,
  input wire [15:0] irq_w,
  input wire [15:0] acc_w,
  output logic stop_req,
  output logic [15:0] irq_lo,
  output logic [15:0] irq_hi,
  output logic [15:0] acc_req_lo,
  output logic [15:0] acc_req_hi
);
  // levels change just after the edge, like registered peripheral sources
  always @(posedge aclk) begin
    irq_lo <= irq_w;
    irq_hi <= irq_w;
    acc_req_lo <= acc_w;
    acc_req_hi <= acc_w;
    if (!aresetn)
      stop_req <= 1'h0;
    else if (wake_req_r)
      stop_req <= 1'h0;
    else if (go_stop)
      stop_req <= 1'h1;
  end
endmodule // pcg_far_side

// ==== sim/peripheral_clock_gating_bench.sv ====
// self-checking bench: register model, stop and wake sequences, write guard
`timescale 1ns/1ps
`include "pcg_map.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module peripheral_clock_gating_bench;
  localparam logic [7:0] A_GL = `PCG_IDX_GATE_LO << 2;
  localparam logic [7:0] A_GD = `PCG_IDX_GUARD << 2;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, go_stop = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic stop_req, stop_active_r, wake_req_r;
  logic [1:0] s_axi_bresp, s_axi_rresp, gd, st;
  logic [15:0] irq_w = 0, acc_w = 0, irq_lo, irq_hi, acc_req_lo, acc_req_hi;
  logic [15:0] clk_en_lo_r, clk_en_hi_r, acc_ok_lo_r, acc_ok_hi_r, pclk_lo, pclk_hi;
  logic [15:0] m [4];
  logic [1:0] gc [4] = '{`PCG_GUARD_ON, `PCG_GUARD_OFF, `PCG_GUARD_OFF_LOCK, `PCG_GUARD_ON_LOCK};
  int num_errors = 0;
  int tests_run = 0;
  pcg_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_req,
    .irq_lo, .irq_hi, .acc_req_lo, .acc_req_hi, .stop_active_r, .wake_req_r, .clk_en_lo_r,
    .clk_en_hi_r, .acc_ok_lo_r, .acc_ok_hi_r, .pclk_lo, .pclk_hi);
  pcg_far_side far_u (.aclk, .aresetn, .go_stop, .wake_req_r, .irq_w, .acc_w, .stop_req,
    .irq_lo, .irq_hi, .acc_req_lo, .acc_req_hi);
  always #4 aclk = ~aclk;
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    tally_and_finish;
  endtask
  function automatic logic [1:0] expr(input logic [7:0] a);
    if (a inside {A_GL, A_GL + 8'h04, A_GL + 8'h08, A_GL + 8'h0C, A_GD, A_GD + 8'h04})
      return `PCG_RESP_OKAY;
    return `PCG_RESP_SLVERR;
  endfunction
  function automatic logic [31:0] mrd(input logic [7:0] a);
    if (expr(a) != `PCG_RESP_OKAY)
      return 32'h0;
    if (a == A_GD)
      return {28'h0, gd, 2'h0};
    if (a == A_GD + 8'h04)
      return {30'h0, st};
    return {16'h0, m[a[3:2]]};
  endfunction
  task automatic w(input logic [7:0] a, input logic [15:0] d, input logic [3:0] sb = 4'hF);
    int i;
    logic [15:0] bm;
    bm = {{8{sb[1]}}, {8{sb[0]}}};
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= sb;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) hang;
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, expr(a))
    // locked guard ignores writes; guard on freezes the gate and keep registers
    if (a == A_GD && !gd[1] && sb[0])
      gd = d[3:2];
    else if (a != A_GD && expr(a) == `PCG_RESP_OKAY && !gd[0])
      m[a[3:2]] = (d & bm | m[a[3:2]] & ~bm) & (a[2] ? `PCG_MASK_HI : `PCG_MASK_LO);
    @(posedge aclk);
  endtask
  task automatic r(input logic [7:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) hang;
    s_axi_rready <= 0;
    `CHK(s_axi_rresp, expr(a))
    `CHK(s_axi_rdata, mrd(a))
    @(posedge aclk);
  endtask
  task automatic ce(input bit s);
    logic [15:0] el, eh;
    el = m[0] & (s ? m[2] : 16'hFFFF);
    eh = m[1] & (s ? m[3] : 16'hFFFF);
    `CHK(clk_en_lo_r, el)
    `CHK(clk_en_hi_r, eh)
    `CHK(acc_ok_lo_r, acc_w & el)
    `CHK(acc_ok_hi_r, acc_w & eh)
  endtask
  task automatic await(input bit wk);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (wk ? wake_req_r : stop_active_r) break;
    end
    if (i == 20) hang;
  endtask
  initial begin
    void'($urandom(54666));
    gd = 0;
    st = 0;
    m = '{default: 0};
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int k = 0; k < 8; k++) r(A_GL + 8'(4 * k));
    r(8'h31);
    $display("reset and map test done");
    for (int k = 0; k < 4; k++)
      w(A_GL + 8'(4 * k), 16'($urandom) & (k[0] ? `PCG_MASK_HI : `PCG_MASK_LO));
    w(A_GL, m[0] | 16'h0401);
    // in the low group only the adc is left alive in stop; high keep bits stay random except TA0
    w(A_GL + 8'h08, 16'h0400);
    w(A_GL + 8'h04, 16'h100F, 4'h2);
    w(A_GL + 8'h0C, m[3] & 16'hFFFE);
    acc_w <= 16'($urandom);
    repeat (6) @(posedge aclk);
    ce(0);
    $display("run mode test done");
    go_stop <= 1;
    @(posedge aclk);
    go_stop <= 0;
    await(0);
    repeat (3) @(posedge aclk);
    ce(1);
    st = 2'h1;
    r(A_GD + 8'h04);
    irq_w <= 16'h0001;
    repeat (8) @(posedge aclk);
    `CHK(wake_req_r, 1'h0)
    irq_w <= 16'h0400;
    await(1);
    `CHK(stop_active_r, 1'h0)
    irq_w <= 16'h0000;
    st = 2'h0;
    repeat (6) @(posedge aclk);
    ce(0);
    r(A_GD + 8'h04);
    $display("stop and wake test done");
    foreach (gc[k]) begin
      w(A_GD, {12'h0, gc[k], 2'h0});
      w(A_GL, 16'($urandom) & `PCG_MASK_LO);
      r(A_GL);
      r(A_GD);
    end
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    gd = 0;
    m = '{default: 0};
    @(posedge aclk);
    w(A_GD, 16'h000C);
    w(A_GD, 16'h0000);
    w(A_GL + 8'h04, 16'h1000);
    r(A_GD);
    r(A_GL + 8'h04);
    $display("guard test done");
    tally_and_finish;
  end
endmodule // peripheral_clock_gating_bench
